// file: core/ftbs_port.sv
// Purpose: flow-through burst memory, 2M words of 36 bits, device side
// Assumes: all inputs synchronous to clk; controller follows the bus order
// Notes: write data follows its address by one qualified edge
`timescale 1ns/1ns
module ftbs_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_qualifier_n,
  input wire logic [ftbs_pkg::ADDR_W-1:0] address,
  input wire logic select_one_n,
  input wire logic select_two,
  input wire logic select_three_n,
  input wire logic write_strobe_n,
  input wire logic advance_or_load,
  input wire logic [ftbs_pkg::LANES-1:0] byte_lane_select_n,
  input wire logic burst_interleaved,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [ftbs_pkg::DATA_W-1:0] data_in,
  output logic [ftbs_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [ftbs_pkg::LANES-1:0] parity_lanes_in,
  output logic [ftbs_pkg::LANES-1:0] parity_lanes_out,
  output logic parity_lanes_oe,
  output logic low_power,
  output logic write_buffer_full
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [ftbs_pkg::WORD_W-1:0] mem [0:ftbs_pkg::DEPTH-1];

  ftbs_pkg::ftbs_op_type op;
  ftbs_pkg::ftbs_op_type next_op;
  logic [ftbs_pkg::ADDR_W-1:0] base_addr;
  logic [ftbs_pkg::ADDR_W-1:0] next_base_addr;
  logic [ftbs_pkg::BURST_W-1:0] burst_count;
  logic [ftbs_pkg::BURST_W-1:0] next_burst_count;
  logic [ftbs_pkg::BURST_W-1:0] burst_low;
  logic [ftbs_pkg::ADDR_W-1:0] access_addr;
  logic was_deselected;
  logic drive_data;
  logic next_drive_data;

  logic qual;
  logic selected;
  logic wr_pending;
  logic [ftbs_pkg::ADDR_W-1:0] wr_addr;

  logic [ftbs_pkg::WORD_W-1:0] in_word;
  logic [ftbs_pkg::LANES-1:0] in_mask;
  logic push_valid;
  logic push_ready;
  logic [ftbs_pkg::ENT_W-1:0] push_entry;
  logic head_valid;
  logic head_ready;
  logic [ftbs_pkg::ENT_W-1:0] head_entry;
  logic buf_almost_full;
  logic [ftbs_pkg::WORD_W-1:0] head_word;
  logic [ftbs_pkg::ADDR_W-1:0] head_addr;
  logic [ftbs_pkg::LANES-1:0] head_mask;
  logic [ftbs_pkg::WORD_W-1:0] rd_word;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Replace the lanes selected by mask with those of src
  function automatic logic [ftbs_pkg::WORD_W-1:0] merge_lanes(
    input logic [ftbs_pkg::WORD_W-1:0] dst,
    input logic [ftbs_pkg::WORD_W-1:0] src,
    input logic [ftbs_pkg::LANES-1:0] mask
  );
    logic [ftbs_pkg::WORD_W-1:0] res;
    res = dst;
    for (int i = 0; i < ftbs_pkg::LANES; i++) begin
      if (mask[i]) begin
        res[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] =
          src[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  // ----------------------------------------------------------------------
  // Qualification and decode
  // ----------------------------------------------------------------------
  // Access and write state below changes only on a qualified edge; pin enables and status flags update every clock
  assign qual = !clock_qualifier_n;
  assign selected = !select_one_n && select_two && !select_three_n;

  // Burst word order within an aligned group of four, for the count that
  // this edge will hold; the sum wraps inside the group on purpose
  assign burst_low = burst_interleaved ?
    (base_addr[ftbs_pkg::BURST_W-1:0] ^ next_burst_count) :
    (base_addr[ftbs_pkg::BURST_W-1:0] + next_burst_count);

  // Access address for the operation taken at this edge
  always_comb begin
    if (advance_or_load) begin
      access_addr = {base_addr[ftbs_pkg::ADDR_W-1:ftbs_pkg::BURST_W],
                     burst_low};
    end else begin
      access_addr = address;
    end
  end

  // Next access: load a new one, continue the burst, or deselect
  always_comb begin
    next_op = op;
    next_base_addr = base_addr;
    next_burst_count = burst_count;
    if (advance_or_load) begin
      next_burst_count = burst_count + 1'b1;
    end else if (selected) begin
      next_base_addr = address;
      next_burst_count = ftbs_pkg::RST_BURST_COUNT;
      if (!write_strobe_n) begin
        // Refused while the write buffer has at most one free slot
        next_op = buf_almost_full ? ftbs_pkg::FTBS_DESELECT :
          ftbs_pkg::FTBS_WRITE;
      end else begin
        next_op = ftbs_pkg::FTBS_READ;
      end
    end else begin
      next_op = ftbs_pkg::FTBS_DESELECT;
    end
    if (advance_or_load && op == ftbs_pkg::FTBS_WRITE && buf_almost_full) begin
      next_op = ftbs_pkg::FTBS_DESELECT;
    end
  end

  // Pins drive only for a read that does not follow a deselect
  always_comb begin
    next_drive_data = (next_op == ftbs_pkg::FTBS_READ) &&
      !(op == ftbs_pkg::FTBS_DESELECT);
  end

  // ----------------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------------
  // Input register of the access; a suspended cycle keeps it as it was
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op <= ftbs_pkg::FTBS_DESELECT;
      base_addr <= ftbs_pkg::RST_ADDR;
      burst_count <= ftbs_pkg::RST_BURST_COUNT;
      drive_data <= 1'b0;
    end else if (qual) begin
      op <= next_op;
      base_addr <= next_base_addr;
      burst_count <= next_burst_count;
      drive_data <= next_drive_data;
    end
  end

  // Deselect history, kept for the low-power flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      was_deselected <= 1'b1;
    end else if (qual) begin
      was_deselected <= (next_op == ftbs_pkg::FTBS_DESELECT);
    end
  end

  // ----------------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------------
  // Remember a write address until its data arrives on the next qualified edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pending <= 1'b0;
      wr_addr <= ftbs_pkg::RST_ADDR;
    end else if (qual) begin
      wr_pending <= (next_op == ftbs_pkg::FTBS_WRITE);
      wr_addr <= access_addr;
    end
  end

  // Pack incoming lanes; a low lane select marks a lane to be written
  always_comb begin
    in_mask = ~byte_lane_select_n;
    for (int i = 0; i < ftbs_pkg::LANES; i++) begin
      in_word[i*ftbs_pkg::LANE_W +: ftbs_pkg::LANE_W] =
        {parity_lanes_in[i], data_in[i*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W]};
    end
  end

  // A write with no lane selected leaves memory alone, so it is not queued
  assign push_valid = qual && wr_pending && (in_mask != '0);
  assign push_entry = {in_mask, wr_addr, in_word};

  // Writes wait here and commit one per qualified edge, held off while asleep
  ftbs_fifo #(
    .WIDTH(ftbs_pkg::ENT_W),
    .DEPTH(ftbs_pkg::FIFO_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_entry),
    .out_valid(head_valid),
    .out_ready(head_ready),
    .out_data(head_entry),
    .almost_full(buf_almost_full)
  );

  assign head_word = head_entry[ftbs_pkg::ENT_WORD_LSB +: ftbs_pkg::WORD_W];
  assign head_addr = head_entry[ftbs_pkg::ENT_ADDR_LSB +: ftbs_pkg::ADDR_W];
  assign head_mask = head_entry[ftbs_pkg::ENT_MASK_LSB +: ftbs_pkg::LANES];
  assign head_ready = qual && !sleep_request;

  // Commit of the oldest write on a qualified edge outside sleep, lane by lane
  always_ff @(posedge clk) begin
    if (head_valid && head_ready) begin
      mem[head_addr] <= merge_lanes(mem[head_addr], head_word,
        head_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Word for the address taken at this edge, with the oldest queued write and the write
  // pushed at this edge folded in so a read right behind a write sees the new data
  always_comb begin
    rd_word = mem[access_addr];
    if (head_valid && head_addr == access_addr) begin
      rd_word = merge_lanes(rd_word, head_word, head_mask);
    end
    if (push_valid && wr_addr == access_addr) begin
      rd_word = merge_lanes(rd_word, in_word, in_mask);
    end
  end

  // No extra output stage: the word leaves on the edge that took its address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= ftbs_pkg::RST_DATA;
      parity_lanes_out <= ftbs_pkg::RST_PARITY;
    end else if (qual && next_op == ftbs_pkg::FTBS_READ) begin
      for (int i = 0; i < ftbs_pkg::LANES; i++) begin
        data_out[i*ftbs_pkg::BYTE_W +: ftbs_pkg::BYTE_W] <=
          rd_word[i*ftbs_pkg::LANE_W +: ftbs_pkg::BYTE_W];
        parity_lanes_out[i] <=
          rd_word[i*ftbs_pkg::LANE_W + ftbs_pkg::BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin direction and status
  // ----------------------------------------------------------------------
  // Enable is sampled each clock; the write data phase and deselect mask it
  // whatever the enable says, which keeps the controller off a driven bus
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_oe <= 1'b0;
      parity_lanes_oe <= 1'b0;
    end else begin
      data_oe <= (qual ? next_drive_data : drive_data) &&
        !output_enable_n;
      parity_lanes_oe <= (qual ? next_drive_data : drive_data) &&
        !output_enable_n;
    end
  end

  // Low power while sleeping or with no access selected
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_power <= 1'b1;
    end else begin
      low_power <= sleep_request ||
        (qual ? (next_op == ftbs_pkg::FTBS_DESELECT) :
          was_deselected);
    end
  end

  // Registered copy of the refuse condition, set on the same edge that turns a write away
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_buffer_full <= 1'b0;
    end else begin
      write_buffer_full <= buf_almost_full || !push_ready;
    end
  end

endmodule : ftbs_port

// file: pkg/ftbs_pkg.sv
// Purpose: shared constants and types for the flow-through burst memory port
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: word is four lanes of nine bits, each lane eight data plus parity
package ftbs_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DEPTH = 2097152;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int BURST_W = 2;

  // ----------------------------------------------------------------------
  // Write buffer entry layout: {lane mask, address, word}
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int ENT_WORD_LSB = 0;
  localparam int ENT_ADDR_LSB = 36;
  localparam int ENT_MASK_LSB = 57;
  localparam int ENT_W = 61;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [BURST_W-1:0] RST_BURST_COUNT = 2'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 21'h00000;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;
  localparam logic [LANES-1:0] RST_PARITY = 4'h0;

  // Access held by the port in the current cycle
  typedef enum logic [1:0] {
    FTBS_DESELECT,
    FTBS_READ,
    FTBS_WRITE
  } ftbs_op_type;

endpackage : ftbs_pkg

// file: core/ftbs_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two, synchronous active-low reset
// Notes: head word is visible while out_valid is high (fall-through)
`timescale 1ns/1ns
module ftbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic almost_full
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[PTR_W:0]);
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  // One slot of margin so a request already in flight still fits
  assign almost_full = (count >= DEPTH[PTR_W:0] - 1'b1);

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : ftbs_fifo

// file: verification/ftbs_port_checker.sv
// Purpose: pin-level checks for the flow-through burst memory port
// Assumes: one clock, synchronous active-low reset
// Notes: output enable is sampled one clock late, as the port chose
`timescale 1ns/1ns
module ftbs_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clock_qualifier_n,
  input wire logic select_one_n,
  input wire logic select_two,
  input wire logic select_three_n,
  input wire logic write_strobe_n,
  input wire logic advance_or_load,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic [ftbs_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic parity_lanes_oe,
  input wire logic low_power
);
  // ------------------------------------------------------------------
  // Access taken at this edge
  // ------------------------------------------------------------------
  wire logic sel = !select_one_n && select_two && !select_three_n;
  wire logic load = !clock_qualifier_n && !advance_or_load;
  wire logic ld_rd = load && sel && write_strobe_n;
  wire logic ld_wr = load && sel && !write_strobe_n;
  wire logic desel = load && !sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  freeze_hold_a:
    assert property (clock_qualifier_n |=> $stable(data_out))
    else $error("read data moved on an unqualified edge");
  write_release_a:
    assert property (ld_wr |=> !data_oe)
    else $error("pins driven in write data phase");
  deselect_release_a:
    assert property (desel |=> !data_oe && !parity_lanes_oe)
    else $error("pins driven while deselected");
  emerge_release_a:
    assert property (desel ##1 ld_rd |=> !data_oe)
    else $error("pins driven on first cycle after deselect");
  read_drive_a:
    assert property (ld_rd && !output_enable_n && data_oe
      && !$past(clock_qualifier_n) |=> data_oe)
    else $error("back to back read not driven");
  enable_release_a:
    assert property (output_enable_n |=> !data_oe)
    else $error("pins driven with enable high");
  sleep_power_a:
    assert property (sleep_request |=> low_power)
    else $error("no low power during sleep");
  desel_power_a:
    assert property (desel |=> low_power)
    else $error("no low power after deselect");
  select_power_a:
    assert property (ld_rd && !sleep_request |=> !low_power)
    else $error("low power while selected");
endmodule : ftbs_port_checker

bind ftbs_port ftbs_port_checker ftbs_port_checker_i (.clk, .rst_n,
  .clock_qualifier_n, .select_one_n, .select_two, .select_three_n,
  .write_strobe_n, .advance_or_load, .output_enable_n, .sleep_request,
  .data_out, .data_oe, .parity_lanes_oe, .low_power);

// file: verification/ftbs_ctrl_model.sv
// Purpose: memory controller model that drives the port's pins
// Assumes: op is called one step after a rising edge
// Notes: op returns one step after the edge that took the access
`timescale 1ns/1ns
module ftbs_ctrl_model (
  input wire logic clk,
  output logic clock_qualifier_n,
  output logic [20:0] address,
  output logic select_one_n,
  output logic select_two,
  output logic select_three_n,
  output logic write_strobe_n,
  output logic advance_or_load,
  output logic [3:0] byte_lane_select_n,
  output logic [35:0] bus_word,
  output logic bus_drive
);
  logic pend = 1'b0;
  logic [35:0] pword = 36'h0;
  logic [3:0] plane = 4'hf;

  // Idle bus at time zero, device deselected
  initial begin
    clock_qualifier_n = 1'b0;
    address = 21'h0;
    {select_one_n, select_two, select_three_n} = 3'h6;
    write_strobe_n = 1'b1;
    advance_or_load = 1'b0;
    byte_lane_select_n = 4'hf;
    bus_word = 36'h0;
    bus_drive = 1'b0;
  end

  // ------------------------------------------------------------------
  // One cycle: 0 deselect, 1/2 load read/write, 3/4 advance, 5 stall
  // ------------------------------------------------------------------
  task automatic op(input int k, input logic [20:0] a,
      input logic [35:0] w, input logic [3:0] bl);
    // A stall raises the qualifier and keeps every other pin as it was: the slow-controller case
    clock_qualifier_n = (k == 5);
    if (k != 5) begin
      advance_or_load = (k > 2);
      {select_one_n, select_two, select_three_n} =
        (k == 0) ? 3'h6 : 3'h2;
      write_strobe_n = !(k == 2 || k == 4);
      address = a;
      // Released bus shows the inverse so stale data never matches
      bus_drive = pend;
      bus_word = pend ? pword : ~bus_word;
      byte_lane_select_n = pend ? plane : ~plane;
      pend = (k == 2 || k == 4);
      pword = w;
      plane = bl;
    end
    @(posedge clk);
    #1;
  endtask : op
endmodule : ftbs_ctrl_model

// file: verification/test_ftbs_port.sv
// Purpose: self-checking bench for the burst memory port
// Assumes: controller model drives pins one step after each edge
// Notes: rows hold plain cases; stall and sleep are written out after
`timescale 1ns/1ns
module test_ftbs_port;
  // Flags f: {output_enable_n, interleaved, expected data_oe}
  typedef struct {
    int k;
    logic [20:0] a;
    logic [35:0] w;
    logic [3:0] bl;
    logic [2:0] f;
  } ftbs_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_interleaved = 1'b0;
  logic clock_qualifier_n, select_one_n, select_two, select_three_n;
  logic write_strobe_n, advance_or_load, bus_drive, data_oe;
  logic parity_lanes_oe, low_power, write_buffer_full;
  logic [20:0] address;
  logic [3:0] byte_lane_select_n, parity_lanes_in, parity_lanes_out;
  logic [31:0] data_in, data_out;
  logic [35:0] bus_word;
  logic [35:0] mem [int];
  int err_count = 0;
  int checked = 0;
  ftbs_row_type rows [$] = '{
    '{2, 21'h10, 36'h123456789, 4'h0, 3'h0},
    '{2, 21'h11, 36'h8a5a55a5a, 4'h0, 3'h0},
    '{1, 21'h10, 36'h0, 4'hf, 3'h1},
    '{2, 21'h10, 36'hfffffffff, 4'ha, 3'h0},
    '{2, 21'h11, 36'h0, 4'hf, 3'h0},
    '{1, 21'h10, 36'h0, 4'hf, 3'h1},
    '{1, 21'h11, 36'h0, 4'hf, 3'h1},
    '{0, 21'h0, 36'h0, 4'hf, 3'h0},
    '{1, 21'h10, 36'h0, 4'hf, 3'h0},
    '{1, 21'h11, 36'h0, 4'hf, 3'h4},
    '{2, 21'h20, 36'h0000000a0, 4'h0, 3'h0},
    '{4, 21'h0, 36'h1000000a1, 4'h0, 3'h0},
    '{4, 21'h0, 36'h2000000a2, 4'h0, 3'h0},
    '{4, 21'h0, 36'h3000000a3, 4'h0, 3'h0},
    '{1, 21'h21, 36'h0, 4'hf, 3'h1},
    '{3, 21'h0, 36'h0, 4'hf, 3'h1},
    '{3, 21'h0, 36'h0, 4'hf, 3'h1},
    '{3, 21'h0, 36'h0, 4'hf, 3'h1},
    '{1, 21'h21, 36'h0, 4'hf, 3'h3},
    '{3, 21'h0, 36'h0, 4'hf, 3'h3},
    '{3, 21'h0, 36'h0, 4'hf, 3'h3},
    '{3, 21'h0, 36'h0, 4'hf, 3'h3}};

  // Shared data wire: whoever enables drives, else a changing pattern
  assign {parity_lanes_in, data_in} = bus_drive ? bus_word :
    data_oe ? {parity_lanes_out, data_out} : ~bus_word;

  always #10 clk = ~clk;

  ftbs_port ftbs_port_i (.clk, .rst_n, .clock_qualifier_n, .address,
    .select_one_n, .select_two, .select_three_n, .write_strobe_n,
    .advance_or_load, .byte_lane_select_n, .burst_interleaved,
    .output_enable_n, .sleep_request, .data_in, .data_out, .data_oe,
    .parity_lanes_in, .parity_lanes_out, .parity_lanes_oe, .low_power,
    .write_buffer_full);
  ftbs_ctrl_model ftbs_ctrl_model_i (.clk, .clock_qualifier_n, .address,
    .select_one_n, .select_two, .select_three_n, .write_strobe_n,
    .advance_or_load, .byte_lane_select_n, .bus_word, .bus_drive);

  task check(input string n, input logic [35:0] s, input logic [35:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task conclude;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // Lanes with a low select take the new byte and its parity bit
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n,
      logic [3:0] bl);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (!bl[i]) begin
        merge[8*i+:8] = n[8*i+:8];
        merge[32+i] = n[32+i];
      end
    end
  endfunction : merge

  // Both drivers on the wire at once would be a contention
  always @(negedge clk) begin
    if (bus_drive) check("clash", data_oe, 1'b0);
  end

  // ------------------------------------------------------------------
  // Reset, table of plain cases, then stall, sleep and full buffer
  // ------------------------------------------------------------------
  initial begin
    ftbs_row_type r;
    logic [20:0] base;
    logic [20:0] ea;
    logic [1:0] cnt;
    base = 21'h0;
    cnt = 2'h0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    check("rst", {data_oe, low_power, write_buffer_full}, 3'h2);
    check("rst data", data_out, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.k == 1 || r.k == 2) begin
        base = r.a;
        cnt = 2'h0;
      end else if (r.k > 2) begin
        cnt = cnt + 2'h1;
      end
      ea = r.f[1] ? base ^ 21'(cnt) : {base[20:2], base[1:0] + cnt};
      if (r.k == 2 || r.k == 4) mem[ea] = merge(mem[ea], r.w, r.bl);
      output_enable_n = r.f[2];
      burst_interleaved = r.f[1];
      ftbs_ctrl_model_i.op(r.k, r.a, r.w, r.bl);
      check("oe", data_oe, r.f[0]);
      check("power", low_power, r.k == 0);
      if (r.k == 1 || r.k == 3)
        check("rdata", {parity_lanes_out, data_out}, mem[ea]);
    end
    // Stall in mid-burst with advance held on the pins: the count must
    // not step on the frozen edges, so a broken freeze shows up here
    burst_interleaved = 1'b0;
    ftbs_ctrl_model_i.op(1, 21'h22, 36'h0, 4'hf);
    ftbs_ctrl_model_i.op(3, 21'h0, 36'h0, 4'hf);
    repeat (2) ftbs_ctrl_model_i.op(5, 21'h0, 36'h0, 4'hf);
    check("stall", {parity_lanes_out, data_out}, mem[21'h23]);
    ftbs_ctrl_model_i.op(3, 21'h0, 36'h0, 4'hf);
    check("resume", {parity_lanes_out, data_out}, mem[21'h20]);
    // Sleep holds commits back, so writes pile up until refused
    sleep_request = 1'b1;
    for (int i = 0; i < 9; i++)
      ftbs_ctrl_model_i.op(2, 21'h30 + 21'(i), 36'(i + 1), 4'h0);
    ftbs_ctrl_model_i.op(0, 21'h0, 36'h0, 4'hf);
    check("sleep", low_power, 1'b1);
    check("full", write_buffer_full, 1'b1);
    sleep_request = 1'b0;
    for (int n = 0; n < 20 && write_buffer_full !== 1'b0; n++)
      ftbs_ctrl_model_i.op(0, 21'h0, 36'h0, 4'hf);
    check("drain", write_buffer_full, 1'b0);
    repeat (8) ftbs_ctrl_model_i.op(0, 21'h0, 36'h0, 4'hf);
    ftbs_ctrl_model_i.op(1, 21'h30, 36'h0, 4'hf);
    check("queued", {parity_lanes_out, data_out}, 36'h1);
    // Eighth write was the last one taken before the buffer filled
    ftbs_ctrl_model_i.op(1, 21'h37, 36'h0, 4'hf);
    check("last queued", {parity_lanes_out, data_out}, 36'h8);
    conclude();
  end

  // Watchdog: the sequence needs well under a hundred cycles
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule : test_ftbs_port
